// file: hw/output_compare_map.vh
// Register offsets, field positions, reset values and encodings of the output compare unit.
`ifndef OUTPUT_COMPARE_MAP_VH
`define OUTPUT_COMPARE_MAP_VH
`define OC_ADDR_CONTROL 4'h0
`define OC_ADDR_PRIMARY 4'h4
`define OC_ADDR_SECONDARY 4'h8
`define OC_ADDR_STATUS 4'hC
`define OC_ADDR_MASK 5'h10
`define OC_BIT_ENABLE 15
`define OC_BIT_IDLE_STOP 13
`define OC_BIT_WIDE 5
`define OC_BIT_FAULT 4
`define OC_BIT_TIMEBASE 3
`define OC_CONTROL_WMASK 32'h0000A02F
`define OC_CONTROL_RESET 32'h00000000
`define OC_MODE_OFF 3'h0
`define OC_MODE_SET_HIGH 3'h1
`define OC_MODE_SET_LOW 3'h2
`define OC_MODE_TOGGLE 3'h3
`define OC_MODE_SINGLE 3'h4
`define OC_MODE_CONT 3'h5
`define OC_MODE_PWM 3'h6
`define OC_MODE_PWM_FAULT 3'h7
`define OC_EV_MATCH 0
`define OC_EV_FAULT 1
`define OC_EV_WIDTH 2
`define OC_RESP_OKAY 2'h0
`define OC_RESP_SLVERR 2'h2
`endif

// file: hw/output_compare_pwm_unit.v
// Output compare and PWM unit with an AXI4-Lite register slave.
//
// Functional notes
// - Unit runs only while control bit 15 enable is one.
// - With bit 13 set, unit halts while the processor idles.
// - Bit 5 selects 32-bit compares; otherwise low 16 bits only.
// - Fault flag bit 4 set by hardware, software writes ignored.
// - Fault flag reads zero outside mode 111.
// - Bit 3 selects second timer when one, first when zero.
// - Mode 111 generates PWM with fault input enabled.
// - Mode 110 generates PWM ignoring fault input.
// - Mode 101 starts low then emits continuous match-driven pulses.
// - Mode 100 starts low then emits exactly one pulse.
// - Mode 011 inverts the output on every primary compare match.
// - Mode 010 starts high and goes low on a match.
// - Mode 001 starts low and goes high on a match.
// - Mode 000 leaves the pin unchanged; primary matches still set the match status flag.
// - Unused control bits ignore writes and read zero.
`include "output_compare_map.vh"
module output_compare_pwm_unit (
    input wire core_clk_i,
    input wire srst_i,
    input wire [31:0] timer_a_count_i,
    input wire [31:0] timer_b_count_i,
    input wire cpu_idle_i,
    input wire fault_n_i,
    output reg compare_output_pin_o,
    output reg irq_o,
    input wire [4:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [4:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_i_unused_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i
);
    reg [31:0] control_ff;
    reg [31:0] primary_ff;
    reg [31:0] secondary_ff;
    reg fault_ff;
    reg [`OC_EV_WIDTH-1:0] status_ff;
    reg [`OC_EV_WIDTH-1:0] mask_ff;
    reg pulse_done_ff;
    reg [2:0] last_mode_ff;
    reg last_on_ff;
    reg [4:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg aw_held_ff;
    reg w_held_ff;

    wire [2:0] mode = control_ff[2:0];
    wire unit_on = control_ff[`OC_BIT_ENABLE];
    wire running = unit_on && !(control_ff[`OC_BIT_IDLE_STOP] && cpu_idle_i);
    wire [31:0] timer_sel = control_ff[`OC_BIT_TIMEBASE] ? timer_b_count_i : timer_a_count_i;
    wire [31:0] cmp_mask = control_ff[`OC_BIT_WIDE] ? 32'hFFFFFFFF : 32'h0000FFFF;
    wire match_pri = running && ((timer_sel & cmp_mask) == (primary_ff & cmp_mask));
    wire match_sec = running && ((timer_sel & cmp_mask) == (secondary_ff & cmp_mask));
    wire fault_act = running && (mode == `OC_MODE_PWM_FAULT) && !fault_n_i;
    // Any change of mode or enable counts as reconfiguration and restarts the mode.
    wire reconfig = (mode != last_mode_ff) || (unit_on != last_on_ff);

    // Write channel: address and data may arrive in either order.
    // A channel counts only once its handshake has happened, so no register changes early.
    wire aw_ok = aw_held_ff || (s_axi_awvalid_i && s_axi_awready_o);
    wire w_ok = w_held_ff || (s_axi_wvalid_i && s_axi_wready_o);
    wire do_write = aw_ok && w_ok && !s_axi_bvalid_o;
    wire [4:0] wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr_i;
    wire [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata_i;
    wire [3:0] wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb_i;
    wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire wr_ctrl = do_write && (wr_addr == {1'b0, `OC_ADDR_CONTROL});
    wire wr_pri = do_write && (wr_addr == {1'b0, `OC_ADDR_PRIMARY});
    wire wr_sec = do_write && (wr_addr == {1'b0, `OC_ADDR_SECONDARY});
    wire wr_stat = do_write && (wr_addr == {1'b0, `OC_ADDR_STATUS});
    wire wr_mask = do_write && (wr_addr == `OC_ADDR_MASK);
    wire wr_known = wr_ctrl || wr_pri || wr_sec || wr_stat || wr_mask;

    reg nxt_pin;
    reg nxt_done;
    always @* begin
        nxt_pin = compare_output_pin_o;
        nxt_done = pulse_done_ff;
        if (!unit_on) begin
            nxt_pin = 1'b0;
            nxt_done = 1'b0;
        end else if (reconfig) begin
            nxt_done = 1'b0;
            if (mode == `OC_MODE_SET_LOW) begin
                nxt_pin = 1'b1;
            end else if (mode != `OC_MODE_TOGGLE && mode != `OC_MODE_OFF) begin
                nxt_pin = 1'b0;
            end
        end else if (running) begin
            case (mode)
                `OC_MODE_OFF: begin
                    nxt_pin = compare_output_pin_o;
                end
                `OC_MODE_SET_HIGH: begin
                    if (match_pri) nxt_pin = 1'b1;
                end
                `OC_MODE_SET_LOW: begin
                    if (match_pri) nxt_pin = 1'b0;
                end
                `OC_MODE_TOGGLE: begin
                    if (match_pri) nxt_pin = !compare_output_pin_o;
                end
                `OC_MODE_SINGLE: begin
                    if (!pulse_done_ff && match_pri) nxt_pin = 1'b1;
                    if (compare_output_pin_o && match_sec) begin
                        nxt_pin = 1'b0;
                        nxt_done = 1'b1;
                    end
                end
                `OC_MODE_CONT: begin
                    if (match_pri) nxt_pin = 1'b1;
                    if (match_sec) nxt_pin = 1'b0;
                end
                `OC_MODE_PWM: begin
                    if (match_pri) nxt_pin = 1'b1;
                    if (match_sec) nxt_pin = 1'b0;
                end
                `OC_MODE_PWM_FAULT: begin
                    if (fault_ff || fault_act) begin
                        nxt_pin = 1'b0;
                    end else begin
                        if (match_pri) nxt_pin = 1'b1;
                        if (match_sec) nxt_pin = 1'b0;
                    end
                end
                default: begin
                    nxt_pin = compare_output_pin_o;
                end
            endcase
        end
    end

    // Register read mux.
    reg [31:0] rd_data;
    reg rd_known;
    always @* begin
        rd_data = 32'h00000000;
        rd_known = 1'b1;
        case (s_axi_araddr_i)
            {1'b0, `OC_ADDR_CONTROL}: begin
                rd_data = control_ff & `OC_CONTROL_WMASK;
                rd_data[`OC_BIT_FAULT] = fault_ff && (mode == `OC_MODE_PWM_FAULT);
            end
            {1'b0, `OC_ADDR_PRIMARY}: rd_data = primary_ff;
            {1'b0, `OC_ADDR_SECONDARY}: rd_data = secondary_ff;
            {1'b0, `OC_ADDR_STATUS}: rd_data = {30'h00000000, status_ff};
            `OC_ADDR_MASK: rd_data = {30'h00000000, mask_ff};
            default: rd_known = 1'b0;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            control_ff <= `OC_CONTROL_RESET;
            primary_ff <= 32'h00000000;
            secondary_ff <= 32'h00000000;
            fault_ff <= 1'b0;
            status_ff <= 2'h0;
            mask_ff <= 2'h0;
            pulse_done_ff <= 1'b0;
            last_mode_ff <= 3'h0;
            last_on_ff <= 1'b0;
            compare_output_pin_o <= 1'b0;
            irq_o <= 1'b0;
            awaddr_ff <= 5'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `OC_RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rvalid_i_unused_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `OC_RESP_OKAY;
        end else begin
            last_mode_ff <= mode;
            last_on_ff <= unit_on;
            compare_output_pin_o <= nxt_pin;
            pulse_done_ff <= nxt_done;
            if (fault_act) begin
                fault_ff <= 1'b1;
            end else if (reconfig) begin
                fault_ff <= 1'b0;
            end
            if (wr_ctrl) begin
                control_ff <= (control_ff & ~(`OC_CONTROL_WMASK & strb_mask))
                    | (wr_data & `OC_CONTROL_WMASK & strb_mask);
            end
            if (wr_pri) primary_ff <= (primary_ff & ~strb_mask) | (wr_data & strb_mask);
            if (wr_sec) secondary_ff <= (secondary_ff & ~strb_mask) | (wr_data & strb_mask);
            if (wr_mask && wr_strb[0]) mask_ff <= wr_data[1:0];
            // Set wins over the write-one-to-clear in the same cycle.
            status_ff <= (status_ff & ~((wr_stat && wr_strb[0]) ? wr_data[1:0] : 2'h0))
                | {fault_act && !fault_ff, match_pri};
            irq_o <= |(status_ff & mask_ff);
            // Write address/data capture; ready is high only while a slot is free.
            s_axi_awready_o <= !aw_held_ff && !s_axi_awready_o && !s_axi_bvalid_o;
            s_axi_wready_o <= !w_held_ff && !s_axi_wready_o && !s_axi_bvalid_o;
            if (s_axi_awvalid_i && s_axi_awready_o && !do_write) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o && !do_write) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata_i;
                wstrb_ff <= s_axi_wstrb_i;
            end
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                s_axi_awready_o <= 1'b0;
                s_axi_wready_o <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_known ? `OC_RESP_OKAY : `OC_RESP_SLVERR;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
            // Read: one cycle arready pulse, data registered the same edge.
            s_axi_arready_o <= s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o;
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_data;
                s_axi_rresp_o <= rd_known ? `OC_RESP_OKAY : `OC_RESP_SLVERR;
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end
endmodule // output_compare_pwm_unit

// file: tb/output_compare_pwm_unit_assertions.sv
// Port-level checker for the output compare unit.
module oc_unit_checker (
    input wire core_clk_i, srst_i, cpu_idle_i, fault_n_i,
    input wire compare_output_pin_o, irq_o,
    input wire [4:0] s_axi_awaddr_i, s_axi_araddr_i,
    input wire s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o,
    input wire s_axi_rvalid_o,
    input wire [1:0] s_axi_rresp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [31:0] ctl_ff;
    reg [31:0] wdat_ff;
    reg wsel_ff;
    reg busy_ff;
    reg [1:0] age_ff;
    wire commit = s_axi_bvalid_o && s_axi_bready_i && wsel_ff;
    wire settled = (age_ff == 2'h3);
    wire running = settled && ctl_ff[15] && !(ctl_ff[13] && cpu_idle_i);
    // The shadow lags the real control word, so checks wait until no write is near.
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            ctl_ff <= 32'h0;
            wdat_ff <= 32'h0;
            wsel_ff <= 1'b0;
            busy_ff <= 1'b0;
            age_ff <= 2'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) wsel_ff <= (s_axi_awaddr_i == 5'h00);
            if (s_axi_wvalid_i && s_axi_wready_o) wdat_ff <= s_axi_wdata_i & 32'h0000A02F;
            if (commit) ctl_ff <= wdat_ff;
            if (s_axi_awvalid_i && s_axi_awready_o) busy_ff <= 1'b1;
            else if (s_axi_bvalid_o && s_axi_bready_i) busy_ff <= 1'b0;
            if (s_axi_awvalid_i || busy_ff) age_ff <= 2'h0;
            else if (!settled) age_ff <= age_ff + 2'h1;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    a_off_pin_low: assert property (
        settled && !ctl_ff[15] |-> !compare_output_pin_o) else $error("pin high while off");
    a_idle_pin_hold: assert property (
        settled && ctl_ff[15] && ctl_ff[13] && cpu_idle_i |=> $stable(compare_output_pin_o))
        else $error("pin moved while idle-stopped");
    a_fault_pin_low: assert property (
        running && ctl_ff[2:0] == 3'h7 && !fault_n_i |=> !compare_output_pin_o)
        else $error("fault did not force pin low");
    a_mode_off_hold: assert property (
        settled && ctl_ff[2:0] == 3'h0 |=> $stable(compare_output_pin_o))
        else $error("pin moved in disabled mode");
    a_read_latency: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("late read data");
    a_write_answer: assert property (
        s_axi_awvalid_i && s_axi_awready_o |-> ##[1:3] s_axi_bvalid_o)
        else $error("late write response");
    a_ar_ready_pulse: assert property (
        s_axi_arready_o |=> !s_axi_arready_o) else $error("arready longer than a cycle");
    a_aw_ready_pulse: assert property (
        s_axi_awready_o |=> !s_axi_awready_o) else $error("awready longer than a cycle");
    a_unmapped_read_err: assert property (
        s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 5'h10 |=> s_axi_rresp_o == 2'h2)
        else $error("unmapped read not refused");
    c_read_err: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2);
    c_irq: cover property (irq_o);
    c_fault: cover property (running && ctl_ff[2:0] == 3'h7 && !fault_n_i);
endmodule // oc_unit_checker

bind output_compare_pwm_unit oc_unit_checker chk_u (.*);

// file: tb/testbench.sv
// Self-checking bench for the output compare unit.
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, idle = 0, flt_n = 1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [4:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    wire [31:0] tma, tmb, rdata;
    wire pin, irq, awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    logic [34:0] exp_q[$];
    int n_fail = 0, checked = 0, cyc = 0;
    timer_source_model tm_u (.core_clk_i(clk), .srst_i(srst), .timer_a_count_o(tma),
        .timer_b_count_o(tmb));
    output_compare_pwm_unit dut_u (.core_clk_i(clk), .srst_i(srst), .timer_a_count_i(tma),
        .timer_b_count_i(tmb), .cpu_idle_i(idle), .fault_n_i(flt_n),
        .compare_output_pin_o(pin), .irq_o(irq), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_i_unused_o(),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    initial begin
        forever #4 clk = ~clk;
    end
    task summarize();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        logic [34:0] e;
        cyc++;
        if (cyc == 40000) begin n_fail++; summarize(); end
        if (rvalid && rready) begin
            e = exp_q.pop_front();
            `CHK(rresp, e[33:32])
            if (e[34]) `CHK(rdata, e[31:0])
        end
    end
    task wr(input [4:0] a, input [31:0] d);
        bit ga, gw;
        ga = 0;
        gw = 0;
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awready) begin awvalid <= 0; ga = 1; end
            if (wready) begin wvalid <= 0; gw = 1; end
        end while (!(ga && gw));
        do @(posedge clk); while (!bvalid);
        bready <= 0;
        `CHK(bresp, (a > 5'h10) ? 2'h2 : 2'h0)
    endtask
    task rd(input [4:0] a, input [31:0] d, input [1:0] r, input c);
        exp_q.push_back({c, r, d});
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        rready <= 0;
    endtask
    task tick();
        @(posedge clk);
        #1;
    endtask
    task till(input [15:0] v);
        do tick(); while (tma[15:0] !== v);
    endtask
    // Primary match lands in the future; the secondary follows 30 counts later.
    task run(input [31:0] c, input [15:0] hi, input e0, e1, e2);
        logic [31:0] p;
        p = {hi, (tma[15:0] + 16'h50 + 16'($urandom % 64)) & 16'hFFFE};
        wr(5'h04, p);
        wr(5'h08, p + 32'h1E);
        wr(5'h00, c);
        repeat (3) tick();
        `CHK(pin, e0)
        till(p[15:0]);
        tick();
        `CHK(pin, e1)
        till(p[15:0] + 16'h1E);
        tick();
        `CHK(pin, e2)
        $display("test with control %h done", c);
    endtask
    initial begin
        void'($urandom(29532));
        repeat (5) @(posedge clk);
        srst <= 0;
        rd(5'h00, 32'h0, 2'h0, 1);
        wr(5'h00, 32'hFFFFFFFF);
        rd(5'h00, 32'h0000A02F, 2'h0, 1);
        rd(5'h14, 32'h0, 2'h2, 0);
        wr(5'h18, 32'h1);
        run(32'h8002, 0, 1, 0, 0);
        run(32'h8003, 0, 0, 1, 1);
        run(32'h8004, 0, 0, 1, 0);
        run(32'h8005, 0, 0, 1, 0);
        run(32'h8006, 0, 0, 1, 0);
        run(32'h8001, 0, 0, 1, 1);
        run(32'h8000, 0, 1, 1, 1);
        run(32'h0003, 0, 0, 0, 0);
        @(posedge clk) idle <= 1;
        run(32'hA001, 0, 0, 0, 0);
        run(32'h8021, 16'h5A5A, 0, 0, 0);
        run(32'h8001, 16'h5A5A, 0, 1, 1);
        @(posedge clk) idle <= 0;
        run(32'hA00A, 0, 1, 1, 1);
        run(32'h8007, 0, 0, 1, 0);
        rd(5'h0C, 32'h1, 2'h0, 1);
        `CHK(irq, 1'b0)
        wr(5'h10, 32'h2);
        wr(5'h04, {16'h0, tma[15:0] + 16'h3C});
        till(tma[15:0] + 16'h30);
        repeat (13) tick();
        `CHK(pin, 1'b1)
        @(posedge clk) flt_n <= 0;
        tick();
        `CHK(pin, 1'b0)
        rd(5'h00, 32'h00008017, 2'h0, 1);
        rd(5'h0C, 32'h3, 2'h0, 1);
        `CHK(irq, 1'b1)
        @(posedge clk) flt_n <= 1;
        wr(5'h0C, 32'h3);
        rd(5'h0C, 32'h0, 2'h0, 1);
        tick();
        `CHK(irq, 1'b0)
        @(posedge clk) flt_n <= 0;
        run(32'h8006, 0, 0, 1, 0);
        rd(5'h00, 32'h00008006, 2'h0, 1);
        $display("fault test done");
        summarize();
    end
endmodule // testbench

// file: tb/timer_source_model.sv
// Behavioural model of the two general-purpose timers feeding the compare unit.
module timer_source_model (
    input wire logic core_clk_i,
    input wire logic srst_i,
    output logic [31:0] timer_a_count_o,
    output logic [31:0] timer_b_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // The second timer only ever shows odd counts, so an even compare value never matches it.
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            timer_a_count_o <= 32'h0;
            timer_b_count_o <= 32'h1;
        end else begin
            timer_a_count_o <= timer_a_count_o + 32'h1;
            timer_b_count_o <= timer_b_count_o + 32'h2;
        end
    end
endmodule // timer_source_model
